// *** verilog/tmr_pkg.sv ***
// Package: register map, field positions and mode codes of the 8-bit timer slice
`default_nettype none

package tmr_pkg;

    // ******************************************************************
    // Register map (data-space offsets)
    // ******************************************************************
    localparam logic [7:0] TMR_OFS_FLAG = 8'h35;
    localparam logic [7:0] TMR_OFS_COUNT = 8'h46;
    localparam logic [7:0] TMR_OFS_CMP_A = 8'h47;
    localparam logic [7:0] TMR_OFS_CMP_B = 8'h48;
    localparam logic [7:0] TMR_OFS_MASK = 8'h6E;
    // I/O space sits this far below data space
    localparam logic [7:0] TMR_IO_SHIFT = 8'h20;
    // From here up only load/store reaches a register
    localparam logic [7:0] TMR_EXT_IO_BASE = 8'h60;

    // ******************************************************************
    // Reset values and count limits
    // ******************************************************************
    localparam logic [7:0] TMR_RST_BYTE = 8'h00;
    localparam logic [2:0] TMR_RST_MASK = 3'h0;
    localparam logic [7:0] TMR_BOTTOM = 8'h00;
    localparam logic [7:0] TMR_MAX = 8'hFF;
    localparam logic [7:0] TMR_ONE = 8'h01;

    // ******************************************************************
    // Flag and enable bit positions (same in flag and mask registers)
    // ******************************************************************
    localparam int TMR_BIT_OVF = 0;
    localparam int TMR_BIT_CMP_A = 1;
    localparam int TMR_BIT_CMP_B = 2;
    localparam int TMR_NUM_FLAGS = 3;

    // ******************************************************************
    // Waveform generation mode codes
    // ******************************************************************
    localparam logic [2:0] TMR_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TMR_MODE_PC_MAX = 3'h1;
    localparam logic [2:0] TMR_MODE_CTC = 3'h2;
    localparam logic [2:0] TMR_MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] TMR_MODE_PC_CMPA = 3'h5;
    localparam logic [2:0] TMR_MODE_FAST_CMPA = 3'h7;

    // Register address hit, in data space or in I/O space
    function automatic logic tmr_hit(input logic [7:0] addr, input logic io_space,
                                     input logic [7:0] ofs);
        if (io_space) begin
            tmr_hit = (ofs < TMR_EXT_IO_BASE) && (addr == ofs - TMR_IO_SHIFT);
        end else begin
            tmr_hit = (addr == ofs);
        end
    endfunction : tmr_hit

endpackage : tmr_pkg

`default_nettype wire

// *** verilog/tmr_flag_cell.sv ***
// Module: one sticky event flag with write-one-to-clear and vector acknowledge
`default_nettype none
`timescale 1ns/100ps

module tmr_flag_cell
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic set_evt,
    input wire logic clr_w1c,
    input wire logic clr_ack,
    output logic flag
);

    typedef struct packed {
        logic flag;
    } tmr_flag_s;

    tmr_flag_s state_reg;
    tmr_flag_s state_next;

    // Set beats either clear so a same-cycle event is never lost
    always_comb begin
        state_next = state_reg;
        if (set_evt) begin
            state_next.flag = 1'b1;
        end else if (clr_w1c || clr_ack) begin
            state_next.flag = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

endmodule : tmr_flag_cell

`default_nettype wire

// *** verilog/tmr_compare_unit.sv ***
// Module: compare of the counter against one compare value, with waveform toggle
`default_nettype none
`timescale 1ns/100ps

module tmr_compare_unit
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic timer_tick,
    input wire logic block,
    input wire logic [7:0] counter_value,
    input wire logic [7:0] compare_value,
    output logic match,
    output logic waveform_out
);

    typedef struct packed {
        logic wave;
    } tmr_cmp_s;

    tmr_cmp_s state_reg;
    tmr_cmp_s state_next;

    // Equality is checked every cycle but only counts on a tick, unless blocked
    assign match = timer_tick && !block && (counter_value == compare_value);

    // Waveform pin flips on every counted match
    always_comb begin
        state_next = state_reg;
        if (match) begin
            state_next.wave = !state_reg.wave;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign waveform_out = state_reg.wave;

endmodule : tmr_compare_unit

`default_nettype wire

// *** verilog/tmr_timer0.sv ***
// Module: 8-bit timer counter with two compares, three flags and irq requests
`default_nettype none
`timescale 1ns/100ps

module tmr_timer0
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic timer_tick,
    input wire logic [2:0] waveform_mode_bits,
    input wire logic global_irq_enable,
    input wire logic [7:0] bus_addr,
    input wire logic bus_io_space,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic ack_overflow,
    input wire logic ack_compare_a,
    input wire logic ack_compare_b,
    output logic irq_overflow,
    output logic irq_compare_a,
    output logic irq_compare_b,
    output logic waveform_out_a,
    output logic waveform_out_b
);

    // ******************************************************************
    // State
    // ******************************************************************
    typedef struct packed {
        logic [7:0] counter_value;
        logic [7:0] compare_value_a;
        logic [7:0] compare_value_b;
        logic [2:0] timer_irq_mask;
        logic count_down;
        logic match_block;
        logic [7:0] rdata;
    } tmr_core_s;

    tmr_core_s state_reg;
    tmr_core_s state_next;

    logic hit_flag;
    logic hit_count;
    logic hit_cmp_a;
    logic hit_cmp_b;
    logic hit_mask;
    logic wr_count;
    logic match_a;
    logic match_b;
    logic ovf_evt;
    logic up_down_mode;
    logic [7:0] top_value;
    logic [TMR_NUM_FLAGS-1:0] set_vec;
    logic [TMR_NUM_FLAGS-1:0] w1c_vec;
    logic [TMR_NUM_FLAGS-1:0] ack_vec;
    logic [TMR_NUM_FLAGS-1:0] timer_flag_register;

    // ******************************************************************
    // Address decode
    // ******************************************************************

    // Each register answers at its data offset and, below the extended area, 0x20 lower
    assign hit_flag = tmr_hit(bus_addr, bus_io_space, TMR_OFS_FLAG);
    assign hit_count = tmr_hit(bus_addr, bus_io_space, TMR_OFS_COUNT);
    assign hit_cmp_a = tmr_hit(bus_addr, bus_io_space, TMR_OFS_CMP_A);
    assign hit_cmp_b = tmr_hit(bus_addr, bus_io_space, TMR_OFS_CMP_B);
    assign hit_mask = tmr_hit(bus_addr, bus_io_space, TMR_OFS_MASK);
    assign wr_count = bus_wr && hit_count;

    // ******************************************************************
    // Mode decode
    // ******************************************************************

    // Top is the fixed maximum or compare A, by mode
    always_comb begin
        unique case (waveform_mode_bits)
            TMR_MODE_CTC, TMR_MODE_PC_CMPA, TMR_MODE_FAST_CMPA: begin
                top_value = state_reg.compare_value_a;
            end
            default: begin
                top_value = TMR_MAX;
            end
        endcase
    end

    assign up_down_mode = (waveform_mode_bits == TMR_MODE_PC_MAX) ||
                          (waveform_mode_bits == TMR_MODE_PC_CMPA);

    // Overflow point per mode; a counter write in the same cycle takes precedence
    always_comb begin
        ovf_evt = 1'b0;
        if (timer_tick && !wr_count) begin
            unique case (waveform_mode_bits)
                TMR_MODE_PC_MAX, TMR_MODE_PC_CMPA: begin
                    // Turn at bottom while coming down
                    ovf_evt = state_reg.count_down &&
                              (state_reg.counter_value == TMR_BOTTOM);
                end
                TMR_MODE_FAST_CMPA: begin
                    ovf_evt = (state_reg.counter_value == top_value);
                end
                default: begin
                    ovf_evt = (state_reg.counter_value == TMR_MAX);
                end
            endcase
        end
    end

    // ******************************************************************
    // Compare units
    // ******************************************************************

    // Compare A: the block bit set by a counter write silences one tick
    tmr_compare_unit u_cmp_a (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .timer_tick(timer_tick),
        .block(state_reg.match_block),
        .counter_value(state_reg.counter_value),
        .compare_value(state_reg.compare_value_a),
        .match(match_a),
        .waveform_out(waveform_out_a)
    );

    // Compare B, same arrangement
    tmr_compare_unit u_cmp_b (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .timer_tick(timer_tick),
        .block(state_reg.match_block),
        .counter_value(state_reg.counter_value),
        .compare_value(state_reg.compare_value_b),
        .match(match_b),
        .waveform_out(waveform_out_b)
    );

    // ******************************************************************
    // Flags
    // ******************************************************************

    // Flag sources, software clears and vector acknowledges, one lane each
    always_comb begin
        set_vec = '0;
        set_vec[TMR_BIT_OVF] = ovf_evt;
        set_vec[TMR_BIT_CMP_A] = match_a;
        set_vec[TMR_BIT_CMP_B] = match_b;
        ack_vec = '0;
        ack_vec[TMR_BIT_OVF] = ack_overflow;
        ack_vec[TMR_BIT_CMP_A] = ack_compare_a;
        ack_vec[TMR_BIT_CMP_B] = ack_compare_b;
        // Writing one clears, zero leaves the flag alone
        w1c_vec = (bus_wr && hit_flag) ? bus_wdata[TMR_NUM_FLAGS-1:0] : '0;
    end

    // One sticky cell per source
    genvar gi;
    generate
        for (gi = 0; gi < TMR_NUM_FLAGS; gi++) begin : g_flag
            tmr_flag_cell u_flag (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .set_evt(set_vec[gi]),
                .clr_w1c(w1c_vec[gi]),
                .clr_ack(ack_vec[gi]),
                .flag(timer_flag_register[gi])
            );
        end
    endgenerate

    // Requests need the global enable, the source enable and the flag
    assign irq_overflow = global_irq_enable && state_reg.timer_irq_mask[TMR_BIT_OVF] &&
                          timer_flag_register[TMR_BIT_OVF];
    assign irq_compare_a = global_irq_enable && state_reg.timer_irq_mask[TMR_BIT_CMP_A] &&
                           timer_flag_register[TMR_BIT_CMP_A];
    assign irq_compare_b = global_irq_enable && state_reg.timer_irq_mask[TMR_BIT_CMP_B] &&
                           timer_flag_register[TMR_BIT_CMP_B];

    // ******************************************************************
    // Counter, registers and read path
    // ******************************************************************

    // Counting runs on ticks; a counter write overrides the tick's count step
    always_comb begin
        state_next = state_reg;
        if (timer_tick) begin
            state_next.match_block = 1'b0;
            if (up_down_mode) begin
                if (!state_reg.count_down && state_reg.counter_value == top_value) begin
                    state_next.count_down = 1'b1;
                    state_next.counter_value = state_reg.counter_value - TMR_ONE;
                end else if (state_reg.count_down &&
                             state_reg.counter_value == TMR_BOTTOM) begin
                    state_next.count_down = 1'b0;
                    state_next.counter_value = state_reg.counter_value + TMR_ONE;
                end else if (state_reg.count_down) begin
                    state_next.counter_value = state_reg.counter_value - TMR_ONE;
                end else begin
                    state_next.counter_value = state_reg.counter_value + TMR_ONE;
                end
            end else begin
                state_next.count_down = 1'b0;
                // Past a lowered top the count runs on and wraps through maximum
                if (state_reg.counter_value == top_value) begin
                    state_next.counter_value = TMR_BOTTOM;
                end else begin
                    state_next.counter_value = state_reg.counter_value + TMR_ONE;
                end
            end
        end
        if (wr_count) begin
            state_next.counter_value = bus_wdata;
            state_next.match_block = 1'b1;
        end
        if (bus_wr && hit_cmp_a) begin
            state_next.compare_value_a = bus_wdata;
        end
        if (bus_wr && hit_cmp_b) begin
            state_next.compare_value_b = bus_wdata;
        end
        if (bus_wr && hit_mask) begin
            state_next.timer_irq_mask = bus_wdata[TMR_NUM_FLAGS-1:0];
        end
        // Read data held until the next read; unmapped reads give zero
        if (bus_rd) begin
            if (hit_count) begin
                state_next.rdata = state_reg.counter_value;
            end else if (hit_cmp_a) begin
                state_next.rdata = state_reg.compare_value_a;
            end else if (hit_cmp_b) begin
                state_next.rdata = state_reg.compare_value_b;
            end else if (hit_flag) begin
                state_next.rdata = {5'h00, timer_flag_register};
            end else if (hit_mask) begin
                state_next.rdata = {5'h00, state_reg.timer_irq_mask};
            end else begin
                state_next.rdata = TMR_RST_BYTE;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg.counter_value <= TMR_RST_BYTE;
            state_reg.compare_value_a <= TMR_RST_BYTE;
            state_reg.compare_value_b <= TMR_RST_BYTE;
            state_reg.timer_irq_mask <= TMR_RST_MASK;
            state_reg.count_down <= 1'b0;
            state_reg.match_block <= 1'b0;
            state_reg.rdata <= TMR_RST_BYTE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus_rdata = state_reg.rdata;

endmodule : tmr_timer0

`default_nettype wire

// *** tb/tmr_timer0_checker.sv ***
// Checker: bus, flag and interrupt relations of the 8-bit timer slice
`timescale 1ns/100ps
`default_nettype none
module tmr_timer0_checker
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic timer_tick,
    input wire logic [2:0] waveform_mode_bits,
    input wire logic global_irq_enable,
    input wire logic [7:0] bus_addr,
    input wire logic bus_io_space,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic ack_overflow,
    input wire logic ack_compare_a,
    input wire logic ack_compare_b,
    input wire logic irq_overflow,
    input wire logic irq_compare_a,
    input wire logic irq_compare_b,
    input wire logic waveform_out_a,
    input wire logic waveform_out_b
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic flag_wr;
    logic count_wr;
    // Data-space writes only; I/O aliases are exercised by reads
    assign flag_wr = bus_wr && !bus_io_space && bus_addr == TMR_OFS_FLAG;
    assign count_wr = bus_wr && !bus_io_space && bus_addr == TMR_OFS_COUNT;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    irq_gate_a: assert property (!global_irq_enable |-> !(irq_overflow || irq_compare_a || irq_compare_b))
        else $error("irq raised with global enable low");
    // Tick excluded: set wins over clear in the same cycle
    w1c_clear_a: assert property (flag_wr && bus_wdata[1] && !timer_tick |=> !irq_compare_a)
        else $error("compare a flag kept after write one");
    ack_clear_a: assert property (ack_compare_b && !timer_tick |=> !irq_compare_b)
        else $error("compare b flag kept after ack");
    ovf_ack_a: assert property (ack_overflow && !timer_tick |=> !irq_overflow)
        else $error("overflow flag kept after ack");
    wave_a_tick_a: assert property (waveform_out_a != $past(waveform_out_a) |-> $past(timer_tick))
        else $error("waveform a moved without a tick");
    wave_b_tick_a: assert property (waveform_out_b != $past(waveform_out_b) |-> $past(timer_tick))
        else $error("waveform b moved without a tick");
    rdata_hold_a: assert property (bus_rdata != $past(bus_rdata) |-> $past(bus_rd))
        else $error("read data moved without a read");
    io_mask_hole_a: assert property (bus_rd && bus_io_space && bus_addr == 8'h4E |=> bus_rdata == 8'h00)
        else $error("mask reachable in io space");
    block_match_a: assert property (count_wr ##1 timer_tick |=> $stable(waveform_out_a) && $stable(waveform_out_b))
        else $error("match on tick after count write");
    irq_rise_a: assert property ($rose(irq_overflow) |-> $past(timer_tick) || $rose(global_irq_enable) || $past(bus_wr))
        else $error("overflow irq rose without cause");
endmodule : tmr_timer0_checker
`default_nettype wire

// *** tb/tmr_core_model.sv ***
// Model: processor core side of the register bus and vector acknowledges
`timescale 1ns/100ps
`default_nettype none
module tmr_core_model
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] bus_rdata,
    output logic [7:0] bus_addr,
    output logic bus_io_space,
    output logic bus_wr,
    output logic bus_rd,
    output logic [7:0] bus_wdata,
    output logic ack_overflow,
    output logic ack_compare_a,
    output logic ack_compare_b
);
    // ****************************************************************
    // Bus cycles, one strobe cycle each, driven at the falling edge
    // ****************************************************************
    initial begin
        {bus_addr, bus_io_space, bus_wr, bus_rd, bus_wdata} = 19'h0;
        {ack_compare_b, ack_compare_a, ack_overflow} = 3'h0;
    end
    task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_io_space = io;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge sys_clk);
        bus_wr = 1'b0;
        bus_wdata = ~d; // Released data must not look held
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_io_space = io;
        bus_rd = 1'b1;
        @(negedge sys_clk);
        bus_rd = 1'b0;
        d = bus_rdata; // Registered answer, taken half a cycle after the read edge
    endtask : rd
    // Vector taken for source idx: 0 overflow, 1 compare a, 2 compare b
    task automatic ack(input int idx);
        @(negedge sys_clk);
        {ack_compare_b, ack_compare_a, ack_overflow} = 3'h1 << idx;
        @(negedge sys_clk);
        {ack_compare_b, ack_compare_a, ack_overflow} = 3'h0;
    endtask : ack
endmodule : tmr_core_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench: register, counting, flag and interrupt scenarios of the timer slice
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import tmr_pkg::*;
;
    logic sys_clk, rst_b, timer_tick, global_irq_enable, bus_io_space, bus_wr, bus_rd;
    logic [2:0] waveform_mode_bits;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic ack_overflow, ack_compare_a, ack_compare_b, irq_overflow, irq_compare_a;
    logic irq_compare_b, waveform_out_a, waveform_out_b;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    // Runs: mode, compare a, start count, ticks, expected count, expected flags
    localparam logic [47:0] RUNS [8] = '{48'h00_10_0E_03_11_02, 48'h00_10_10_01_11_00,
        48'h00_10_1F_02_21_04, 48'h00_10_FE_02_00_01, 48'h04_10_FE_02_00_01,
        48'h02_10_0F_03_01_02, 48'h07_10_0F_02_00_03, 48'h05_10_0F_02_0F_02};
    // Reads: address, io space, expected value
    localparam logic [23:0] RDS [5] = '{24'h48_00_20, 24'h27_01_10, 24'h6E_00_07,
        24'h4E_01_00, 24'h50_00_00};
    localparam logic [7:0] OFS [5] = '{8'h35, 8'h46, 8'h47, 8'h48, 8'h6E};
    tmr_timer0 tmr_timer0_i (.*);
    tmr_core_model tmr_core_model_i (.*);
    // ****************************************************************
    // Clock, timeout and helpers
    // ****************************************************************
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    // A hung handshake would otherwise run forever
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rdc(input string what, input logic [7:0] a, input logic io,
                       input logic [7:0] exp);
        logic [7:0] v;
        tmr_core_model_i.rd(a, io, v);
        check(what, v, exp);
    endtask : rdc
    // Ticks start in the cycle right after the last write edge
    task automatic ticks(input int n);
        timer_tick = 1'b1;
        repeat (n) @(negedge sys_clk);
        timer_tick = 1'b0;
    endtask : ticks
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst_b, timer_tick, global_irq_enable, waveform_mode_bits} = 6'h0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        foreach (OFS[i]) rdc("reset value", OFS[i], 1'b0, 8'h00);
        tmr_core_model_i.wr(8'h28, 1'b1, 8'h20);
        tmr_core_model_i.wr(8'h27, 1'b1, 8'h10);
        tmr_core_model_i.wr(TMR_OFS_MASK, 1'b0, 8'hFF);
        tmr_core_model_i.wr(8'h4E, 1'b1, 8'h00);
        foreach (RDS[i]) rdc("decode", RDS[i][23:16], RDS[i][8], RDS[i][7:0]);
        global_irq_enable = 1'b1;
        foreach (RUNS[i]) begin
            waveform_mode_bits = RUNS[i][42:40];
            tmr_core_model_i.wr(TMR_OFS_CMP_A, 1'b0, RUNS[i][39:32]);
            tmr_core_model_i.wr(TMR_OFS_COUNT, 1'b0, RUNS[i][31:24]); // Loaded while stopped
            ticks(int'(RUNS[i][23:16]));
            rdc("count", TMR_OFS_COUNT, 1'b0, RUNS[i][15:8]);
            rdc("flags", TMR_OFS_FLAG, 1'b0, RUNS[i][7:0]);
            check("irqs", {5'h00, irq_compare_b, irq_compare_a, irq_overflow}, RUNS[i][7:0]);
            tmr_core_model_i.wr(TMR_OFS_FLAG, 1'b0, 8'hFF);
        end
        rdc("flags cleared", TMR_OFS_FLAG, 1'b0, 8'h00);
        // All three flags at once, then each vector taken in turn
        // Fast mode with top at compare A: the phase-correct run left the count heading down
        waveform_mode_bits = TMR_MODE_FAST_CMPA;
        tmr_core_model_i.wr(TMR_OFS_CMP_B, 1'b0, 8'h10);
        tmr_core_model_i.wr(TMR_OFS_COUNT, 1'b0, 8'h0F);
        ticks(2);
        global_irq_enable = 1'b0;
        @(negedge sys_clk);
        check("irqs off", {5'h00, irq_compare_b, irq_compare_a, irq_overflow}, 8'h00);
        global_irq_enable = 1'b1;
        for (int b = 2; b >= 0; b--) begin
            tmr_core_model_i.ack(b);
            rdc("flags after ack", TMR_OFS_FLAG, 1'b0, 8'h07 >> (3 - b));
        end
        // Five counted A matches and two B matches so far, each one a toggle
        check("waves", {6'h00, waveform_out_b, waveform_out_a}, 8'h01);
        test_done();
    end
endmodule : tb_top
bind tmr_timer0 tmr_timer0_checker tmr_timer0_checker_i (.*);
`default_nettype wire
